// [byte_core_pkg.sv]
// shared constants and types for the byte core instruction decoder
package byte_core_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int CYCLE_PERIODS = 4;
   localparam int INSTR_CYCLE_NS = CYCLE_PERIODS * CLK_PERIOD_NS;
   localparam int WORD_W = 16;
   localparam int PC_W = 21;
   localparam int BANK_W = 4;
   localparam int FADDR_W = 12;
   // field positions within one program word
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 12;
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   localparam int BIT_LO = 9;
   localparam int PTR_LO = 4;
   localparam int CALL_BIT = 8;
   localparam int RET_BIT = 0;
   // opcode patterns
   localparam logic [3:0] NIB_SECOND = 4'hF;
   localparam logic [3:0] NIB_BIT_CLEAR = 4'h9;
   localparam logic [3:0] NIB_MOVE_FF = 4'hC;
   localparam logic [3:0] NIB_LIT_CTRL = 4'h0;
   localparam logic [3:0] NIB_WIDE = 4'hE;
   localparam logic [3:0] NIB_BYTE_LO = 4'h1;
   localparam logic [3:0] NIB_BYTE_HI = 4'h6;
   localparam logic [3:0] NIB_BIT_LO = 4'h7;
   localparam logic [3:0] NIB_BIT_HI = 4'hB;
   localparam logic [7:0] HI_BRANCH_NEG = 8'hE6;
   localparam logic [7:0] HI_GOTO = 8'hEF;
   localparam logic [6:0] HI_CALL = 7'h76;
   localparam logic [9:0] HI_LOAD_PTR = 10'h3B8;
   // access bank split
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

   typedef enum logic [3:0] {
      CLS_BYTE = 4'b0001,
      CLS_BIT = 4'b0010,
      CLS_LIT = 4'b0100,
      CLS_CTRL = 4'b1000
   } op_class_t;

   typedef enum logic [2:0] {
      ST_EXEC = 3'b001,
      ST_SECOND = 3'b010,
      ST_FLUSH = 3'b100
   } exec_state_t;
endpackage

// [cycle_phase_divider.sv]
// divides the clock into instruction cycles of fixed oscillator periods
`timescale 1ns/1ps
module cycle_phase_divider import byte_core_pkg::*; #(
   parameter int PERIODS = CYCLE_PERIODS
) (
   input wire logic clk_sys,
   input wire logic rst,
   output logic cycle_en,
   output logic [$clog2(PERIODS)-1:0] phase
);
   typedef struct packed {
      logic [$clog2(PERIODS)-1:0] cnt;
   } div_state_t;

   div_state_t r_reg;
   div_state_t r_next;
   localparam logic [$clog2(PERIODS)-1:0] LAST =
      ($clog2(PERIODS))'(PERIODS - 1);

   always_comb begin
      r_next = r_reg;
      if (r_reg.cnt == LAST) begin
         r_next.cnt = '0;
      end else begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign cycle_en = (r_reg.cnt == LAST);
   assign phase = r_reg.cnt;
endmodule

// [bank_address_former.sv]
// forms the full file address from the operand and bank selection
`timescale 1ns/1ps
module bank_address_former import byte_core_pkg::*; (
   input wire logic [7:0] file_sel,
   input wire logic access_sel,
   input wire logic [BANK_W-1:0] bank_select_register,
   output logic [FADDR_W-1:0] file_addr
);
   always_comb begin
      if (access_sel) begin
         file_addr = {bank_select_register, file_sel};
      end else if (file_sel < ACCESS_SPLIT) begin
         file_addr = {ACCESS_LOW_BANK, file_sel};
      end else begin
         file_addr = {ACCESS_HIGH_BANK, file_sel};
      end
   end
endmodule

// [byte_core_instruction_decode.sv]
// instruction decode and execution timing for the 8-bit core
`timescale 1ns/1ps
module byte_core_instruction_decode import byte_core_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WORD_W-1:0] prog_word,
   input wire logic negative_flag,
   input wire logic [BANK_W-1:0] bank_select_register,
   output logic [PC_W-1:0] prog_addr,
   output logic cycle_en,
   output logic [1:0] cycle_phase,
   output logic exec_valid,
   output op_class_t op_class,
   output logic [FADDR_W-1:0] file_addr,
   output logic working_register_write,
   output logic file_write,
   output logic [2:0] bit_index,
   output logic bit_clear_file,
   output logic [7:0] literal_value,
   output logic [1:0] pointer_sel,
   output logic indirect_pointer_register_write,
   output logic [FADDR_W-1:0] pointer_value,
   output logic call_mode,
   output logic [1:0] table_mode,
   output logic nop_exec
);
   typedef struct packed {
      exec_state_t st;
      logic [PC_W-1:0] pc;
      logic [WORD_W-1:0] first;
      logic exec_valid;
      op_class_t cls;
      logic [FADDR_W-1:0] faddr;
      logic working_register_wr;
      logic file_wr;
      logic [2:0] bit_idx;
      logic bclr;
      logic [7:0] lit;
      logic [1:0] ptr_sel;
      logic ptr_wr;
      logic [FADDR_W-1:0] ptr_val;
      logic call_mode;
      logic [1:0] tbl_mode;
      logic nop_exec;
   } core_state_t;

   core_state_t r_reg;
   core_state_t r_next;
   logic [FADDR_W-1:0] bank_addr;
   logic [3:0] nib;
   logic is_second;
   logic is_goto;
   logic is_call;
   logic is_load_ptr;
   logic is_move_ff;
   logic is_double;
   logic is_bclr;
   logic is_bneg;
   op_class_t cls_now;
   logic [PC_W-1:0] pc_seq;
   logic [PC_W-1:0] pc_bneg;
   logic [PC_W-1:0] pc_far;

   cycle_phase_divider #(
      .PERIODS(CYCLE_PERIODS)
   ) u_div (
      .clk_sys(clk_sys),
      .rst(rst),
      .cycle_en(cycle_en),
      .phase(cycle_phase)
   );

   bank_address_former u_bank (
      .file_sel(prog_word[7:0]),
      .access_sel(prog_word[ACCESS_BIT]),
      .bank_select_register(bank_select_register),
      .file_addr(bank_addr)
   );

   // opcode field selects the operation group
   assign nib = prog_word[OPC_HI:OPC_LO];
   assign is_second = (nib == NIB_SECOND);
   assign is_goto = (prog_word[15:8] == HI_GOTO);
   assign is_call = (prog_word[15:9] == HI_CALL);
   assign is_load_ptr = (prog_word[15:6] == HI_LOAD_PTR);
   assign is_move_ff = (nib == NIB_MOVE_FF);
   assign is_double = is_goto | is_call | is_load_ptr | is_move_ff;
   assign is_bclr = (nib == NIB_BIT_CLEAR);
   assign is_bneg = (prog_word[15:8] == HI_BRANCH_NEG);

   always_comb begin
      if (nib == NIB_LIT_CTRL && prog_word[11]) begin
         cls_now = CLS_LIT;
      end else if (nib == NIB_LIT_CTRL) begin
         cls_now = CLS_CTRL;
      end else if (nib >= NIB_BYTE_LO && nib <= NIB_BYTE_HI) begin
         cls_now = CLS_BYTE;
      end else if (nib >= NIB_BIT_LO && nib <= NIB_BIT_HI) begin
         cls_now = CLS_BIT;
      end else if (is_move_ff) begin
         cls_now = CLS_BYTE;
      end else if (is_load_ptr) begin
         cls_now = CLS_LIT;
      end else begin
         cls_now = CLS_CTRL;
      end
   end

   assign pc_seq = r_reg.pc + PC_STEP;
   // offset is in words, so it doubles into a byte address
   assign pc_bneg = pc_seq +
      {{(PC_W-9){prog_word[7]}}, prog_word[7:0], 1'b0};
   assign pc_far = PC_W'({prog_word[11:0], r_reg.first[7:0], 1'b0});

   always_comb begin
      r_next = r_reg;
      r_next.exec_valid = 1'b0;
      r_next.working_register_wr = 1'b0;
      r_next.file_wr = 1'b0;
      r_next.bclr = 1'b0;
      r_next.ptr_wr = 1'b0;
      r_next.nop_exec = 1'b0;
      // all work happens once per instruction cycle
      if (cycle_en) begin
         r_next.exec_valid = 1'b1;
         case (r_reg.st)
            ST_EXEC: begin
               r_next.pc = pc_seq;
               r_next.cls = cls_now;
               r_next.faddr = bank_addr;
               r_next.bit_idx = prog_word[11:BIT_LO];
               r_next.lit = prog_word[7:0];
               r_next.call_mode = prog_word[RET_BIT];
               r_next.tbl_mode = prog_word[1:0];
               if (is_second) begin
                  r_next.nop_exec = 1'b1;
               end else if (is_double) begin
                  // first half only, no write strobe or exec_valid is raised yet
                  r_next.first = prog_word;
                  r_next.st = ST_SECOND;
                  r_next.exec_valid = 1'b0;
               end else begin
                  case (cls_now)
                     CLS_BYTE: begin
                        r_next.working_register_wr = ~prog_word[DEST_BIT];
                        r_next.file_wr = prog_word[DEST_BIT];
                     end
                     CLS_BIT: begin
                        r_next.bclr = is_bclr;
                     end
                     CLS_LIT: begin
                        r_next.lit = prog_word[7:0];
                     end
                     CLS_CTRL: begin
                        if (is_bneg && negative_flag) begin
                           r_next.pc = pc_bneg;
                           r_next.st = ST_FLUSH;
                        end
                     end
                     default: begin
                        r_next.nop_exec = 1'b1;
                     end
                  endcase
               end
            end
            ST_SECOND: begin
               r_next.st = ST_EXEC;
               r_next.pc = pc_seq;
               if (r_reg.first[15:6] == HI_LOAD_PTR) begin
                  r_next.ptr_wr = 1'b1;
                  r_next.ptr_sel = r_reg.first[PTR_LO+1:PTR_LO];
                  r_next.ptr_val = {r_reg.first[3:0], prog_word[7:0]};
               end else if (r_reg.first[OPC_HI:OPC_LO] == NIB_MOVE_FF) begin
                  r_next.file_wr = 1'b1;
                  r_next.faddr = prog_word[FADDR_W-1:0];
               end else begin
                  r_next.pc = pc_far;
                  r_next.call_mode = r_reg.first[CALL_BIT];
               end
            end
            ST_FLUSH: begin
               // pipeline refill cycle does nothing
               r_next.nop_exec = 1'b1;
               r_next.st = ST_EXEC;
            end
            default: begin
               r_next.st = ST_EXEC;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r_reg <= '0;
         r_reg.st <= ST_EXEC;
         r_reg.cls <= CLS_CTRL;
         r_reg.pc <= PC_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prog_addr = r_reg.pc;
   assign exec_valid = r_reg.exec_valid;
   assign op_class = r_reg.cls;
   assign file_addr = r_reg.faddr;
   assign working_register_write = r_reg.working_register_wr;
   assign file_write = r_reg.file_wr;
   assign bit_index = r_reg.bit_idx;
   assign bit_clear_file = r_reg.bclr;
   assign literal_value = r_reg.lit;
   assign pointer_sel = r_reg.ptr_sel;
   assign indirect_pointer_register_write = r_reg.ptr_wr;
   assign pointer_value = r_reg.ptr_val;
   assign call_mode = r_reg.call_mode;
   assign table_mode = r_reg.tbl_mode;
   assign nop_exec = r_reg.nop_exec;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic exec_now;
   assign exec_now = cycle_en && (r_reg.st == ST_EXEC);

   sequence s_flush_wait;
      (r_reg.st == ST_FLUSH) [*4];
   endsequence

   sequence s_flush_nop;
      s_flush_wait ##1 (nop_exec && exec_valid);
   endsequence

   a_cycle_length: assert property (
      cycle_en |=> !cycle_en [*3] ##1 cycle_en)
      else $error("instruction cycle is not four clocks");

   a_bit_clear: assert property (
      exec_now && is_bclr |=>
         bit_clear_file && bit_index == $past(prog_word[11:9]))
      else $error("bit clear not decoded");

   a_dest_select: assert property (
      exec_now && cls_now == CLS_BYTE && !is_double |=>
         working_register_write == !$past(prog_word[9]) &&
         file_write == $past(prog_word[9]))
      else $error("byte destination wrong");

   a_second_nop: assert property (
      exec_now && is_second |=> nop_exec && !file_write &&
         !working_register_write && !bit_clear_file &&
         prog_addr == $past(prog_addr) + PC_STEP)
      else $error("lone second word did something");

   a_branch_target: assert property (
      exec_now && is_bneg && negative_flag |=>
         prog_addr == $past(pc_bneg) &&
         (prog_addr != $past(pc_seq) || $past(prog_word[7:0]) == 8'h00))
      else $error("branch target wrong");

   a_branch_flush: assert property (
      exec_now && is_bneg && negative_flag |=> s_flush_nop)
      else $error("taken branch missing nop cycle");

   a_branch_skip: assert property (
      exec_now && is_bneg && !negative_flag |=>
         r_reg.st == ST_EXEC && prog_addr == $past(pc_seq))
      else $error("untaken branch not sequential");

   a_double_cycles: assert property (
      exec_now && is_double && !is_second |=>
         !exec_valid ##0 (r_reg.st == ST_SECOND) [*4] ##1
         (r_reg.st == ST_EXEC && exec_valid))
      else $error("double word not two cycles");

   a_ptr_load: assert property (
      cycle_en && r_reg.st == ST_SECOND &&
         r_reg.first[15:6] == HI_LOAD_PTR |=>
         indirect_pointer_register_write &&
         pointer_value == {$past(r_reg.first[3:0]), $past(prog_word[7:0])})
      else $error("pointer load wrong");

   a_single_pulse: assert property (
      exec_valid |=> !exec_valid [*3])
      else $error("more than one execute per cycle");
endmodule

// [prog_mem_model.sv]
// program memory model answering the decoder's fetch address
`timescale 1ns/1ps
module prog_mem_model import byte_core_pkg::*; (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic [PC_W-1:0] prog_addr,
   output logic [WORD_W-1:0] prog_word
);
   // 512 words, upper address bits alias like a small flash
   logic [WORD_W-1:0] mem [0:511];
   logic [WORD_W-1:0] d1;
   logic [WORD_W-1:0] d2;
   initial begin
      for (int i = 0; i < 512; i++) begin
         mem[i] = 16'hFFFF;
      end
   end
   // slow mode answers two clocks late; the core tolerates up to three
   always_ff @(posedge clk_sys) begin
      d1 <= mem[prog_addr[9:1]];
      d2 <= d1;
   end
   assign prog_word = slow ? d2 : mem[prog_addr[9:1]];
endmodule

// [byte_core_instruction_decode_tb_top.sv]
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module byte_core_instruction_decode_tb_top import byte_core_pkg::*;;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic negative_flag = 1'b0;
   logic slow = 1'b0;
   logic [BANK_W-1:0] bank_select_register = 4'h5;
   logic [WORD_W-1:0] prog_word;
   logic [PC_W-1:0] prog_addr;
   logic cycle_en, exec_valid, working_register_write, file_write;
   logic bit_clear_file, indirect_pointer_register_write, call_mode;
   logic nop_exec;
   logic [1:0] cycle_phase, pointer_sel, table_mode;
   logic [2:0] bit_index;
   logic [7:0] literal_value;
   logic [FADDR_W-1:0] file_addr, pointer_value;
   op_class_t op_class;
   int num_errors = 0;
   int n_checks = 0;
   int gap;
   int cycles = 0;

   always #2 clk_sys = ~clk_sys;

   byte_core_instruction_decode dut (.clk_sys(clk_sys), .rst(rst),
      .prog_word(prog_word), .negative_flag(negative_flag),
      .bank_select_register(bank_select_register),
      .prog_addr(prog_addr), .cycle_en(cycle_en),
      .cycle_phase(cycle_phase), .exec_valid(exec_valid),
      .op_class(op_class), .file_addr(file_addr),
      .working_register_write(working_register_write),
      .file_write(file_write), .bit_index(bit_index),
      .bit_clear_file(bit_clear_file), .literal_value(literal_value),
      .pointer_sel(pointer_sel),
      .indirect_pointer_register_write(indirect_pointer_register_write),
      .pointer_value(pointer_value), .call_mode(call_mode),
      .table_mode(table_mode), .nop_exec(nop_exec));

   prog_mem_model pm (.clk_sys(clk_sys), .slow(slow),
      .prog_addr(prog_addr), .prog_word(prog_word));

   task summarize;
      if (num_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // whole run needs about 120 clocks
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         summarize();
      end
   end

   task restart;
      @(posedge clk_sys);
      #1;
      rst = 1'b1;
      for (int i = 0; i < 512; i++) pm.mem[i] = 16'hFFFF;
   endtask

   task go;
      repeat (4) @(posedge clk_sys);
      #1;
      rst = 1'b0;
   endtask

   // waits for the next executed cycle; gap counts clocks since the last
   task step(input int g_exp, input logic [PC_W-1:0] pc_exp,
      input logic nop_exp);
      gap = 0;
      do begin
         @(posedge clk_sys);
         #1;
         gap++;
      end while (exec_valid !== 1'b1 && gap < 20);
      if (g_exp > 0) `CHK("gap", g_exp, gap)
      `CHK("prog_addr", pc_exp, prog_addr)
      `CHK("nop_exec", nop_exp, nop_exec)
      `CHK("cycle_phase", 2'h0, cycle_phase)
   endtask

   task bitc(input logic [2:0] b, input logic [FADDR_W-1:0] fa);
      `CHK("bit_clear_file", 1'b1, bit_clear_file)
      `CHK("bit_index", b, bit_index)
      `CHK("file_addr", fa, file_addr)
      `CHK("op_class", CLS_BIT, op_class)
   endtask

   task t_bit_clear;
      restart;
      pm.mem[0] = 16'h9F80;
      pm.mem[1] = 16'h9070;
      pm.mem[2] = 16'h9A10;
      bank_select_register = 4'h5;
      go;
      step(0, 21'h000002, 1'b0);
      bitc(3'h7, 12'h580);
      step(4, 21'h000004, 1'b0);
      bitc(3'h0, 12'hF70);
      step(4, 21'h000006, 1'b0);
      bitc(3'h5, 12'h010);
   endtask

   task t_byte_dest;
      restart;
      pm.mem[0] = 16'h2080;
      pm.mem[1] = 16'h2380;
      bank_select_register = 4'hA;
      go;
      step(0, 21'h000002, 1'b0);
      `CHK("working_register_write", 1'b1, working_register_write)
      `CHK("file_write", 1'b0, file_write)
      `CHK("file_addr", 12'hF80, file_addr)
      `CHK("op_class", CLS_BYTE, op_class)
      step(4, 21'h000004, 1'b0);
      `CHK("working_register_write", 1'b0, working_register_write)
      `CHK("file_write", 1'b1, file_write)
      `CHK("file_addr", 12'hA80, file_addr)
      // last clock of the cycle carries the enable pulse
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("cycle_en", 1'b1, cycle_en)
      `CHK("cycle_phase", 2'h3, cycle_phase)
   endtask

   // both offset extremes, with memory answering late
   task t_taken;
      restart;
      pm.mem[0] = 16'hE67F;
      pm.mem[128] = 16'hE680;
      pm.mem[1] = 16'h0E55;
      negative_flag = 1'b1;
      slow = 1'b1;
      go;
      step(0, 21'h000100, 1'b0);
      step(4, 21'h000100, 1'b1);
      step(4, 21'h000002, 1'b0);
      step(4, 21'h000002, 1'b1);
      step(4, 21'h000004, 1'b0);
      `CHK("literal", 8'h55, literal_value)
      `CHK("op_class", CLS_LIT, op_class)
      slow = 1'b0;
   endtask

   task t_untaken;
      restart;
      pm.mem[0] = 16'hE680;
      pm.mem[1] = 16'h0E33;
      negative_flag = 1'b0;
      go;
      step(0, 21'h000002, 1'b0);
      step(4, 21'h000004, 1'b0);
      `CHK("literal", 8'h33, literal_value)
   endtask

   task t_double;
      restart;
      pm.mem[0] = 16'hEE2A;
      pm.mem[1] = 16'hF0BC;
      pm.mem[2] = 16'hC123;
      pm.mem[3] = 16'hF456;
      pm.mem[4] = 16'hF123;
      pm.mem[5] = 16'hEF20;
      pm.mem[6] = 16'hF000;
      pm.mem[32] = 16'hED30;
      pm.mem[33] = 16'hF000;
      pm.mem[48] = 16'h000A;
      go;
      step(0, 21'h000004, 1'b0);
      `CHK("ptr_write", 1'b1, indirect_pointer_register_write)
      `CHK("pointer_sel", 2'h2, pointer_sel)
      `CHK("pointer_value", 12'hABC, pointer_value)
      step(8, 21'h000008, 1'b0);
      `CHK("file_write", 1'b1, file_write)
      `CHK("file_addr", 12'h456, file_addr)
      step(4, 21'h00000A, 1'b1);
      step(8, 21'h000040, 1'b0);
      step(8, 21'h000060, 1'b0);
      `CHK("call_mode", 1'b1, call_mode)
      step(4, 21'h000062, 1'b0);
      `CHK("table_mode", 2'h2, table_mode)
      `CHK("op_class", CLS_CTRL, op_class)
   endtask

   initial begin
      t_bit_clear;
      t_byte_dest;
      t_taken;
      t_untaken;
      t_double;
      summarize;
   end
endmodule
